// ### rtl/i2cs_map.svh
`ifndef I2CS_MAP_SVH
`define I2CS_MAP_SVH

// Register offsets
`define I2CS_OFF_CTRL 4'h0
`define I2CS_OFF_STATUS 4'h1
`define I2CS_OFF_OWN_ADDR 4'h2
`define I2CS_OFF_TX_DATA 4'h3
`define I2CS_OFF_RX_DATA 4'h4
`define I2CS_OFF_IRQ_STAT 4'h5
`define I2CS_OFF_IRQ_MASK 4'h6

// Control fields
`define I2CS_CTRL_TX 0
`define I2CS_CTRL_ACK 1

// Status fields
`define I2CS_STAT_BUSY 0
`define I2CS_STAT_RW 1
`define I2CS_STAT_ACK_RECEIVED_FLAG 2
`define I2CS_STAT_HIT 3

// Interrupt event fields
`define I2CS_IRQ_W 5
`define I2CS_IRQ_START 0
`define I2CS_IRQ_STOP 1
`define I2CS_IRQ_ADDR 2
`define I2CS_IRQ_RXB 3
`define I2CS_IRQ_TXB 4

// Reset values
`define I2CS_RST_ACK_RECEIVED_FLAG 1'b1
`define I2CS_RST_OWN_ADDR 7'h50

// Bit clocks per byte: eight data bits, then the ack clock
`define I2CS_ACK_BIT 4'h8
`define I2CS_LAST_BIT 4'h7
// A START parks the count here; the SCL fall that closes the START wraps it to zero
`define I2CS_START_CNT 4'hf
`endif

// ### rtl/i2cs_pkg.sv
package i2cs_pkg;

    typedef enum logic [4:0] {
        I2CS_ST_IDLE = 5'b00001,
        I2CS_ST_ADDR = 5'b00010,
        I2CS_ST_RX = 5'b00100,
        I2CS_ST_TX = 5'b01000,
        I2CS_ST_WAIT = 5'b10000
    } i2cs_state_e;

    typedef struct packed {
        logic scl_meta;
        logic scl_sync;
        logic scl_prev;
        logic sda_meta;
        logic sda_sync;
        logic sda_prev;
        i2cs_state_e st;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] txsh;
        logic hit;
        logic busy;
        logic rw;
        logic ack_received_flag;
        logic ctrl_tx;
        logic ack_ctl;
        logic [6:0] own_addr;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
        logic [4:0] irq_stat;
        logic [4:0] irq_mask;
        logic sda_oe_n;
        logic sda_o;
        logic irq;
        logic [7:0] rdata;
    } i2cs_state_s;

endpackage

// ### rtl/i2cs_ctrl.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "i2cs_map.svh"

module i2cs_ctrl
    import i2cs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    // Interrupt
    output logic irq_o,
    // I2C pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o
);

    i2cs_state_s q_reg;
    i2cs_state_s q_next;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Edges look only at the second and third stages, never the first
    assign scl_rise = q_reg.scl_sync & ~q_reg.scl_prev;
    assign scl_fall = ~q_reg.scl_sync & q_reg.scl_prev;
    assign start_det = q_reg.scl_sync & q_reg.scl_prev & ~q_reg.sda_sync & q_reg.sda_prev;
    assign stop_det = q_reg.scl_sync & q_reg.scl_prev & q_reg.sda_sync & ~q_reg.sda_prev;

    function automatic logic [4:0] sticky_update(input logic [4:0] cur, input logic [4:0] clr,
                                                 input logic [4:0] set);
        // Set wins over a clear in the same cycle so no event is lost
        sticky_update = (cur & ~clr) | set;
    endfunction

    always_comb begin
        logic [4:0] ev;
        logic [4:0] clr;
        ev = '0;
        clr = '0;
        q_next = q_reg;

        q_next.scl_meta = scl_i;
        q_next.scl_sync = q_reg.scl_meta;
        q_next.scl_prev = q_reg.scl_sync;
        q_next.sda_meta = sda_i;
        q_next.sda_sync = q_reg.sda_meta;
        q_next.sda_prev = q_reg.sda_sync;

        // Data bits are taken on the rising edge
        if (scl_rise) begin
            if ((q_reg.st == I2CS_ST_ADDR || q_reg.st == I2CS_ST_RX) &&
                q_reg.cnt < `I2CS_ACK_BIT) begin
                q_next.shift = {q_reg.shift[6:0], q_reg.sda_sync};
            end
            if (q_reg.st == I2CS_ST_TX && q_reg.cnt == `I2CS_ACK_BIT) begin
                q_next.ack_received_flag = q_reg.sda_sync;
            end
        end

        // Drive changes happen on the falling edge, while SCL is low
        if (scl_fall) begin
            case (q_reg.st)
                I2CS_ST_ADDR: begin
                    if (q_reg.cnt == `I2CS_LAST_BIT) begin
                        q_next.rw = q_reg.shift[0];
                        q_next.hit = (q_reg.shift[7:1] == q_reg.own_addr);
                        q_next.sda_oe_n = ~(q_reg.shift[7:1] == q_reg.own_addr);
                        q_next.cnt = `I2CS_ACK_BIT;
                    end else if (q_reg.cnt == `I2CS_ACK_BIT) begin
                        q_next.cnt = 4'h0;
                        if (!q_reg.hit) begin
                            q_next.st = I2CS_ST_WAIT;
                            q_next.sda_oe_n = 1'b1;
                        end else if (q_reg.ctrl_tx) begin
                            q_next.st = I2CS_ST_TX;
                            q_next.txsh = q_reg.tx_data;
                            q_next.sda_oe_n = q_reg.tx_data[7];
                        end else begin
                            q_next.st = I2CS_ST_RX;
                            q_next.sda_oe_n = 1'b1;
                        end
                        ev[`I2CS_IRQ_ADDR] = q_reg.hit;
                    end else begin
                        q_next.cnt = q_reg.cnt + 4'h1;
                    end
                end
                I2CS_ST_RX: begin
                    if (q_reg.cnt == `I2CS_LAST_BIT) begin
                        q_next.rx_data = q_reg.shift;
                        // A one here withholds the ack; firmware clears it to keep going
                        q_next.sda_oe_n = q_reg.ack_ctl;
                        q_next.cnt = `I2CS_ACK_BIT;
                        ev[`I2CS_IRQ_RXB] = 1'b1;
                    end else if (q_reg.cnt == `I2CS_ACK_BIT) begin
                        q_next.sda_oe_n = 1'b1;
                        q_next.cnt = 4'h0;
                    end else begin
                        q_next.cnt = q_reg.cnt + 4'h1;
                    end
                end
                I2CS_ST_TX: begin
                    if (q_reg.cnt == `I2CS_LAST_BIT) begin
                        q_next.sda_oe_n = 1'b1;
                        q_next.cnt = `I2CS_ACK_BIT;
                    end else if (q_reg.cnt == `I2CS_ACK_BIT) begin
                        q_next.cnt = 4'h0;
                        ev[`I2CS_IRQ_TXB] = 1'b1;
                        if (!q_reg.ack_received_flag) begin
                            // Byte acked: reload from the transmit holding register
                            q_next.txsh = q_reg.tx_data;
                            q_next.sda_oe_n = q_reg.tx_data[7];
                        end else begin
                            q_next.st = I2CS_ST_WAIT;
                            q_next.sda_oe_n = 1'b1;
                        end
                    end else begin
                        q_next.txsh = {q_reg.txsh[6:0], 1'b0};
                        q_next.sda_oe_n = q_reg.txsh[6];
                        q_next.cnt = q_reg.cnt + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Bus conditions override bit handling; a repeated START restarts addressing
        if (start_det) begin
            q_next.busy = 1'b1;
            q_next.st = I2CS_ST_ADDR;
            // Without parking, the fall after START would count as an address bit
            q_next.cnt = `I2CS_START_CNT;
            q_next.hit = 1'b0;
            q_next.sda_oe_n = 1'b1;
            ev[`I2CS_IRQ_START] = 1'b1;
        end else if (stop_det) begin
            // Only a STOP brings a released transmitter back to idle
            q_next.busy = 1'b0;
            q_next.st = I2CS_ST_IDLE;
            q_next.cnt = 4'h0;
            q_next.hit = 1'b0;
            q_next.sda_oe_n = 1'b1;
            ev[`I2CS_IRQ_STOP] = 1'b1;
        end

        // Register writes
        if (we_i) begin
            if (addr_i == `I2CS_OFF_CTRL) begin
                q_next.ctrl_tx = wdata_i[`I2CS_CTRL_TX];
                q_next.ack_ctl = wdata_i[`I2CS_CTRL_ACK];
            end else if (addr_i == `I2CS_OFF_OWN_ADDR) begin
                q_next.own_addr = wdata_i[6:0];
            end else if (addr_i == `I2CS_OFF_TX_DATA) begin
                q_next.tx_data = wdata_i;
            end else if (addr_i == `I2CS_OFF_IRQ_STAT) begin
                clr = wdata_i[4:0];
            end else if (addr_i == `I2CS_OFF_IRQ_MASK) begin
                q_next.irq_mask = wdata_i[4:0];
            end
        end
        q_next.irq_stat = sticky_update(q_reg.irq_stat, clr, ev);
        q_next.irq = |(q_next.irq_stat & q_next.irq_mask);

        // Read data stands for one cycle only
        q_next.rdata = 8'h00;
        if (re_i) begin
            if (addr_i == `I2CS_OFF_CTRL) begin
                q_next.rdata[`I2CS_CTRL_TX] = q_reg.ctrl_tx;
                q_next.rdata[`I2CS_CTRL_ACK] = q_reg.ack_ctl;
            end else if (addr_i == `I2CS_OFF_STATUS) begin
                q_next.rdata[`I2CS_STAT_BUSY] = q_reg.busy;
                q_next.rdata[`I2CS_STAT_RW] = q_reg.rw;
                q_next.rdata[`I2CS_STAT_ACK_RECEIVED_FLAG] = q_reg.ack_received_flag;
                q_next.rdata[`I2CS_STAT_HIT] = q_reg.hit;
            end else if (addr_i == `I2CS_OFF_OWN_ADDR) begin
                q_next.rdata = {1'b0, q_reg.own_addr};
            end else if (addr_i == `I2CS_OFF_TX_DATA) begin
                q_next.rdata = q_reg.tx_data;
            end else if (addr_i == `I2CS_OFF_RX_DATA) begin
                q_next.rdata = q_reg.rx_data;
            end else if (addr_i == `I2CS_OFF_IRQ_STAT) begin
                q_next.rdata = {3'h0, q_reg.irq_stat};
            end else if (addr_i == `I2CS_OFF_IRQ_MASK) begin
                q_next.rdata = {3'h0, q_reg.irq_mask};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg <= '0;
            q_reg.scl_meta <= 1'b1;
            q_reg.scl_sync <= 1'b1;
            q_reg.scl_prev <= 1'b1;
            q_reg.sda_meta <= 1'b1;
            q_reg.sda_sync <= 1'b1;
            q_reg.sda_prev <= 1'b1;
            q_reg.st <= I2CS_ST_IDLE;
            q_reg.ack_received_flag <= `I2CS_RST_ACK_RECEIVED_FLAG;
            q_reg.own_addr <= `I2CS_RST_OWN_ADDR;
            q_reg.sda_oe_n <= 1'b1;
        end else begin
            q_reg <= q_next;
        end
    end

    assign rdata_o = q_reg.rdata;
    assign irq_o = q_reg.irq;
    assign sda_o = q_reg.sda_o;
    assign sda_oe_n_o = q_reg.sda_oe_n;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_busy_set: assert property (start_det |=> q_reg.busy)
        else $error("busy flag not set after START");

    chk_busy_clear: assert property (stop_det |=> !q_reg.busy)
        else $error("busy flag not cleared after STOP");

    chk_role_select: assert property (
        scl_fall && !start_det && !stop_det && q_reg.st == I2CS_ST_ADDR &&
        q_reg.cnt == `I2CS_ACK_BIT && q_reg.hit
        |=> (q_reg.st == I2CS_ST_TX) == $past(q_reg.ctrl_tx))
        else $error("slave role does not follow transmit select");

    chk_rx_ack_drive: assert property (
        scl_fall && !start_det && !stop_det && q_reg.st == I2CS_ST_RX &&
        q_reg.cnt == `I2CS_LAST_BIT
        |=> q_reg.sda_oe_n == $past(q_reg.ack_ctl) && q_reg.cnt == `I2CS_ACK_BIT)
        else $error("ack bit on ninth clock does not follow ack control");

    chk_rw_capture: assert property (
        scl_fall && q_reg.st == I2CS_ST_ADDR && q_reg.cnt == `I2CS_LAST_BIT
        |=> q_reg.rw == $past(q_reg.shift[0]))
        else $error("direction flag not taken from eighth bit");

    chk_ack_sample: assert property (
        scl_rise && q_reg.st == I2CS_ST_TX && q_reg.cnt == `I2CS_ACK_BIT
        |=> q_reg.ack_received_flag == $past(q_reg.sda_sync))
        else $error("received ack not sampled on ninth rising edge");

    chk_tx_continue: assert property (
        scl_fall && !start_det && !stop_det && q_reg.st == I2CS_ST_TX &&
        q_reg.cnt == `I2CS_ACK_BIT && !q_reg.ack_received_flag
        |=> q_reg.st == I2CS_ST_TX && q_reg.cnt == 4'h0 &&
            q_reg.sda_oe_n == $past(q_reg.tx_data[7]))
        else $error("transmitter stopped after acked byte");

    chk_nack_release: assert property (
        scl_fall && !start_det && !stop_det && q_reg.st == I2CS_ST_TX &&
        q_reg.cnt == `I2CS_ACK_BIT && q_reg.ack_received_flag
        |=> q_reg.st == I2CS_ST_WAIT && q_reg.sda_oe_n [*2])
        else $error("SDA not released after missing ack");

    chk_irq_level: assert property (
        $rose(q_reg.irq_stat[`I2CS_IRQ_START]) && q_reg.irq_mask[`I2CS_IRQ_START] |-> irq_o)
        else $error("unmasked start event did not raise interrupt");

    chk_start_count: assert property (
        start_det |=> q_reg.st == I2CS_ST_ADDR && q_reg.cnt == `I2CS_START_CNT)
        else $error("bit count not parked after START");

    chk_addr_ack: assert property (
        scl_fall && q_reg.st == I2CS_ST_ADDR && q_reg.cnt == `I2CS_LAST_BIT &&
        q_reg.shift[7:1] == q_reg.own_addr
        |=> !q_reg.sda_oe_n && q_reg.hit)
        else $error("matching address not acknowledged");

    chk_rx_release: assert property (
        scl_fall && !start_det && !stop_det && q_reg.st == I2CS_ST_RX &&
        q_reg.cnt == `I2CS_ACK_BIT
        |=> q_reg.sda_oe_n && q_reg.cnt == 4'h0)
        else $error("SDA held after the ninth clock of a received byte");

    chk_wait_released: assert property (
        q_reg.st == I2CS_ST_WAIT |-> q_reg.sda_oe_n)
        else $error("SDA driven while waiting for the bus");

    chk_busy_idle: assert property (
        q_reg.st == I2CS_ST_IDLE |-> !q_reg.busy)
        else $error("busy flag set while idle");

    chk_open_drain: assert property (sda_o == 1'b0)
        else $error("SDA output value not low");

    chk_rdata_idle: assert property (!$past(re_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside the read cycle");

    cov_write_byte: cover property (scl_fall && q_reg.st == I2CS_ST_RX &&
                                    q_reg.cnt == `I2CS_LAST_BIT);
    cov_read_acked: cover property (scl_fall && q_reg.st == I2CS_ST_TX &&
                                    q_reg.cnt == `I2CS_ACK_BIT && !q_reg.ack_received_flag);
    cov_read_nack: cover property (q_reg.st == I2CS_ST_TX ##1 q_reg.st == I2CS_ST_WAIT);
    cov_rep_start: cover property (start_det && q_reg.busy);
    cov_addr_foreign: cover property (scl_fall && q_reg.st == I2CS_ST_ADDR &&
                                      q_reg.cnt == `I2CS_ACK_BIT && !q_reg.hit);

endmodule

// ### tb/i2cs_master_model.sv
`timescale 1ns/1ns

module i2cs_master_model (
    // Clock and wire level
    input wire logic clk_i,
    input wire logic sda_i,
    // Bus drive, open drain on SDA
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // SCL low 5 clocks, high 3; the slave answers some 3 clocks after a fall
    task automatic bit_x(input logic b, output logic s);
        sda_low_o <= ~b;
        tick(4);
        scl_o <= 1'b1;
        tick(3);
        s = sda_i;
        scl_o <= 1'b0;
        tick(1);
    endtask

    // Also serves as repeated start when entered with SCL low
    task automatic start();
        sda_low_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
        tick(1);
    endtask

    // Frees the bus, also after the slave let SDA go on a missing ack
    task automatic stop();
        sda_low_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_low_o <= 1'b0;
        tick(4);
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, ak);
    endtask

    task automatic rbyte(input logic ack, output logic [7:0] q);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            q[i] = s;
        end
        bit_x(~ack, s);
    endtask
endmodule

// ### tb/i2c_slave_control_status_tb.sv
`timescale 1ns/1ns
`include "i2cs_map.svh"

module i2c_slave_control_status_tb;
    logic clk_i = 1'b0;
    logic rst_i, we_i, re_i, scl_w, m_low, sda_o, sda_oe_n, irq_o, ak, sda_w;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o, q;
    int error_cnt, checks;
    // Offset in the top nibble, reset value below; 7 and 15 are unmapped
    logic [11:0] rows [9] = '{12'h000, 12'h104, 12'h250, 12'h300, 12'h400, 12'h500,
        12'h600, 12'h700, 12'hf00};

    // Pull-up wire: low if either party pulls
    assign sda_w = ~m_low & (sda_oe_n | sda_o);

    always #25 clk_i = ~clk_i;

    i2cs_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .scl_i(scl_w),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));

    i2cs_master_model m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_low_o(m_low));

    task automatic end_of_test();
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    task automatic stat(input logic [7:0] mk, input logic [7:0] e, input string n);
        rd(`I2CS_OFF_STATUS, q);
        chk(n, e, q & mk);
    endtask

    task automatic reg_loop();
        for (int i = 0; i < 9; i++) begin
            rd(rows[i][11:8], q);
            chk("reset_value", rows[i][7:0], q);
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end

    initial begin
        rst_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        we_i = 1'b0;
        re_i = 1'b0;
        error_cnt = 0;
        checks = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        reg_loop();
        wr(`I2CS_OFF_IRQ_MASK, 8'h1f);
        // Master writes three bytes; the middle one is refused by firmware
        m.start();
        stat(8'h01, 8'h01, "busy_start");
        m.wbyte({7'h50, 1'b0}, ak);
        chk("addr_ack", 8'h00, {7'h00, ak});
        stat(8'h02, 8'h00, "rw_write");
        m.wbyte(8'ha5, ak);
        chk("rx_ack", 8'h00, {7'h00, ak});
        rd(`I2CS_OFF_RX_DATA, q);
        chk("rx_data", 8'ha5, q);
        wr(`I2CS_OFF_CTRL, 8'h02);
        m.wbyte(8'h3c, ak);
        chk("rx_nack", 8'h01, {7'h00, ak});
        wr(`I2CS_OFF_CTRL, 8'h00);
        m.wbyte(8'h11, ak);
        chk("rx_ack_again", 8'h00, {7'h00, ak});
        m.stop();
        stat(8'h01, 8'h00, "busy_stop");
        rd(`I2CS_OFF_IRQ_STAT, q);
        chk("irq_stat", 8'h0f, q);
        chk("irq_level", 8'h01, {7'h00, irq_o});
        wr(`I2CS_OFF_IRQ_MASK, 8'h00);
        m.tick(2);
        chk("irq_masked", 8'h00, {7'h00, irq_o});
        wr(`I2CS_OFF_IRQ_STAT, 8'h1f);
        rd(`I2CS_OFF_IRQ_STAT, q);
        chk("irq_cleared", 8'h00, q);
        // Master reads two bytes and refuses the second
        wr(`I2CS_OFF_TX_DATA, 8'h96);
        wr(`I2CS_OFF_CTRL, 8'h01);
        m.start();
        m.wbyte({7'h50, 1'b1}, ak);
        chk("addr_ack_rd", 8'h00, {7'h00, ak});
        stat(8'h02, 8'h02, "rw_read");
        wr(`I2CS_OFF_TX_DATA, 8'h5a);
        m.rbyte(1'b1, q);
        chk("tx_byte0", 8'h96, q);
        stat(8'h04, 8'h00, "ack_received_flag_ack");
        // A wrong reload after the refusal would pull SDA low
        wr(`I2CS_OFF_TX_DATA, 8'h00);
        m.rbyte(1'b0, q);
        chk("tx_byte1", 8'h5a, q);
        stat(8'h04, 8'h04, "ack_received_flag_nack");
        m.tick(8);
        chk("sda_released", 8'h01, {7'h00, sda_oe_n});
        chk("sda_value", 8'h00, {7'h00, sda_o});
        m.stop();
        stat(8'h01, 8'h00, "busy_stop_rd");
        rd(`I2CS_OFF_IRQ_STAT, q);
        chk("irq_tx_byte", 8'h10, q & 8'h10);
        // Foreign address is not acknowledged
        wr(`I2CS_OFF_CTRL, 8'h00);
        m.start();
        m.wbyte({7'h11, 1'b0}, ak);
        chk("foreign_addr", 8'h01, {7'h00, ak});
        // Repeated START to a newly written own address; the reset below must undo it
        wr(`I2CS_OFF_OWN_ADDR, 8'h11);
        m.start();
        stat(8'h01, 8'h01, "busy_rep_start");
        m.wbyte({7'h11, 1'b0}, ak);
        chk("rep_start_ack", 8'h00, {7'h00, ak});
        m.stop();
        // Reset in mid-run restores every register
        rst_i <= 1'b1;
        m.tick(2);
        rst_i <= 1'b0;
        reg_loop();
        end_of_test();
    end
endmodule
